// ---- core/dtm_cfg.svh ----
// constants for the dram training and mode timing block
// assumes a 10 MHz core clock; all times are in picoseconds
`ifndef DTM_CFG_SVH
`define DTM_CFG_SVH

`define DTM_CLK_PERIOD_PS 100000
`define DTM_CA_W 6
`define DTM_TMR_W 4

// longest times round down, never below one cycle
`define DTM_MAX_CYC(t) (((t) / `DTM_CLK_PERIOD_PS) < 1 ? 1 : ((t) / `DTM_CLK_PERIOD_PS))
// least times round up
`define DTM_MIN_CYC(t) (((t) + `DTM_CLK_PERIOD_PS - 1) / `DTM_CLK_PERIOD_PS)

`define DTM_ASYNC_SAMPLE_DELAY_PS 20000
`define DTM_VREF_LONG_PS 250000
`define DTM_VREF_SHORT_PS 80000
`define DTM_DQ_FLOAT_DELAY_PS 1500
`define DTM_ODT_SWITCH_PS 20000

`define DTM_ASYNC_SAMPLE_DELAY_CYC `DTM_MAX_CYC(`DTM_ASYNC_SAMPLE_DELAY_PS)
`define DTM_VREF_LONG_CYC `DTM_MAX_CYC(`DTM_VREF_LONG_PS)
`define DTM_VREF_SHORT_CYC `DTM_MAX_CYC(`DTM_VREF_SHORT_PS)
`define DTM_DQ_FLOAT_DELAY_CYC `DTM_MIN_CYC(`DTM_DQ_FLOAT_DELAY_PS)
`define DTM_ODT_SWITCH_CYC `DTM_MIN_CYC(`DTM_ODT_SWITCH_PS)

`endif

// ---- core/dtm_pkg.sv ----
// types shared by the training and mode timing block
// no assumptions beyond a synthesizable flow
package dtm_pkg;
   typedef enum logic [1:0]
   {
      DTM_IDLE = 2'b00,
      DTM_TRAIN = 2'b01,
      DTM_EXIT = 2'b10
   } dtm_state_type;
endpackage

// ---- core/dtm_delay_timer.sv ----
// one-shot countdown timer for the training core
// assumes an asynchronous active-low reset already synchronised
`timescale 1ns/10ps
`default_nettype none
`include "dtm_cfg.svh"

module dtm_delay_timer
   import dtm_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic load_i,
   input wire logic [`DTM_TMR_W-1:0] load_val_i,
   output logic busy_o,
   output logic done_o,
   output logic expiring_o
);

   logic [`DTM_TMR_W-1:0] cnt_r;
   logic [`DTM_TMR_W-1:0] cnt_nxt;
   logic done_r;
   logic done_nxt;

   always_comb
   begin
      cnt_nxt = cnt_r;
      done_nxt = 1'b0;
      // a reload restarts the count, so only the latest event survives
      if (load_i)
      begin
         cnt_nxt = load_val_i;
      end
      else if (cnt_r != '0)
      begin
         cnt_nxt = cnt_r - `DTM_TMR_W'(1);
         done_nxt = (cnt_r == `DTM_TMR_W'(1));
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_r <= '0;
         done_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   assign busy_o = (cnt_r != '0);
   assign done_o = done_r;
   // last counted cycle, so a follower flop can drop together with the count
   assign expiring_o = !load_i && (cnt_r == `DTM_TMR_W'(1));

endmodule
`default_nettype wire

// ---- core/dtm_training_core.sv ----
// dram-side command bus training sequencer: sample return, vref step, dq float, odt
// assumes cke, cs, ca and strobe inputs are synchronous to ref_clk_i
`timescale 1ns/10ps
`default_nettype none
`include "dtm_cfg.svh"

module dtm_training_core
   import dtm_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic train_en_i,
   input wire logic cke_i,
   input wire logic cs_i,
   input wire logic [`DTM_CA_W-1:0] ca_i,
   input wire logic dqs_t_i,
   input wire logic dqs_c_i,
   input wire logic vref_step_i,
   input wire logic vref_multi_i,
   output logic [`DTM_CA_W-1:0] dq_o,
   output logic [`DTM_CA_W-1:0] dq_oe_o,
   output logic sample_valid_o,
   output logic training_o,
   output logic vref_busy_o,
   output logic odt_on_o
);

   logic rst_meta_r;
   logic rst_n_r;

   // reset asserts at once, releases through two flops
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   dtm_state_type state_r;
   dtm_state_type state_nxt;
   logic cke_prev_r;
   logic [`DTM_CA_W-1:0] sample_r;
   logic [`DTM_CA_W-1:0] sample_nxt;
   logic [`DTM_CA_W-1:0] dq_r;
   logic [`DTM_CA_W-1:0] dq_nxt;
   logic [`DTM_CA_W-1:0] dq_oe_r;
   logic [`DTM_CA_W-1:0] dq_oe_nxt;
   logic valid_r;
   logic valid_nxt;
   logic vref_busy_r;
   logic vref_busy_nxt;
   logic odt_r;
   logic odt_nxt;
   logic odt_target_r;
   logic odt_target_nxt;
   logic cke_fall;
   logic cke_rise;
   logic train_cmd;
   logic vref_load;
   logic [`DTM_TMR_W-1:0] vref_len;
   logic float_load;
   logic samp_done;
   logic vref_busy;
   logic vref_expiring;
   logic float_done;
   logic odt_done;
   logic strobe_parked;

   assign cke_fall = cke_prev_r && !cke_i;
   assign cke_rise = !cke_prev_r && cke_i;
   // strobe is parked while the far end prepares entry; used only to qualify it
   assign strobe_parked = !dqs_t_i && dqs_c_i;
   assign train_cmd = (state_r == DTM_TRAIN) && cs_i;
   assign vref_load = (state_r == DTM_TRAIN) && vref_step_i && !vref_busy;
   assign vref_len = vref_multi_i ? `DTM_TMR_W'(`DTM_VREF_LONG_CYC) : `DTM_TMR_W'(`DTM_VREF_SHORT_CYC);
   assign float_load = (state_r == DTM_TRAIN) && cke_rise;

   // each new command restarts the wait, so an early sample is dropped
   dtm_delay_timer u_samp_tmr
   (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n_r),
      .load_i(train_cmd),
      .load_val_i(`DTM_TMR_W'(`DTM_ASYNC_SAMPLE_DELAY_CYC)),
      .busy_o(),
      .done_o(samp_done),
      .expiring_o()
   );

   dtm_delay_timer u_vref_tmr
   (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n_r),
      .load_i(vref_load),
      .load_val_i(vref_len),
      .busy_o(vref_busy),
      .done_o(),
      .expiring_o(vref_expiring)
   );

   dtm_delay_timer u_float_tmr
   (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n_r),
      .load_i(float_load),
      .load_val_i(`DTM_TMR_W'(`DTM_DQ_FLOAT_DELAY_CYC)),
      .busy_o(),
      .done_o(float_done),
      .expiring_o()
   );

   dtm_delay_timer u_odt_tmr
   (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n_r),
      .load_i(cke_fall || cke_rise),
      .load_val_i(`DTM_TMR_W'(`DTM_ODT_SWITCH_CYC)),
      .busy_o(),
      .done_o(odt_done),
      .expiring_o()
   );

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         DTM_IDLE:
         begin
            // entry only on a clean cke fall with the strobe parked
            if (train_en_i && cke_fall && strobe_parked)
            begin
               state_nxt = DTM_TRAIN;
            end
         end
         DTM_TRAIN:
         begin
            if (cke_rise)
            begin
               state_nxt = DTM_EXIT;
            end
         end
         DTM_EXIT:
         begin
            if (float_done)
            begin
               state_nxt = DTM_IDLE;
            end
         end
         default:
         begin
            state_nxt = DTM_IDLE;
         end
      endcase
   end

   always_comb
   begin
      sample_nxt = sample_r;
      valid_nxt = valid_r;
      if (train_cmd)
      begin
         sample_nxt = ca_i;
         valid_nxt = 1'b0;
      end
      else if (samp_done && state_r == DTM_TRAIN)
      begin
         valid_nxt = 1'b1;
      end
      else if (state_r == DTM_IDLE)
      begin
         valid_nxt = 1'b0;
      end
   end

   // per-bit dq driver: hold through exit until the float delay ends
   genvar gi;
   generate
      for (gi = 0; gi < `DTM_CA_W; gi = gi + 1)
      begin : g_dq
         always_comb
         begin
            dq_nxt[gi] = dq_r[gi];
            dq_oe_nxt[gi] = dq_oe_r[gi];
            if (samp_done && state_r == DTM_TRAIN)
            begin
               dq_nxt[gi] = sample_r[gi];
               dq_oe_nxt[gi] = 1'b1;
            end
            else if (float_done || state_r == DTM_IDLE)
            begin
               dq_oe_nxt[gi] = 1'b0;
            end
         end
      end
   endgenerate

   always_comb
   begin
      odt_target_nxt = odt_target_r;
      odt_nxt = odt_r;
      if (cke_fall || cke_rise)
      begin
         odt_target_nxt = cke_i;
      end
      // termination follows cke only after the switching delay
      if (odt_done)
      begin
         odt_nxt = odt_target_r;
      end
      // busy flop tracks the step timer cycle for cycle
      vref_busy_nxt = vref_load || (vref_busy && !vref_expiring);
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         state_r <= DTM_IDLE;
         cke_prev_r <= 1'b1;
         sample_r <= '0;
         dq_r <= '0;
         dq_oe_r <= '0;
         valid_r <= 1'b0;
         vref_busy_r <= 1'b0;
         odt_r <= 1'b1;
         odt_target_r <= 1'b1;
      end
      else
      begin
         state_r <= state_nxt;
         cke_prev_r <= cke_i;
         sample_r <= sample_nxt;
         dq_r <= dq_nxt;
         dq_oe_r <= dq_oe_nxt;
         valid_r <= valid_nxt;
         vref_busy_r <= vref_busy_nxt;
         odt_r <= odt_nxt;
         odt_target_r <= odt_target_nxt;
      end
   end

   assign dq_o = dq_r;
   assign dq_oe_o = dq_oe_r;
   assign sample_valid_o = valid_r;
   assign training_o = (state_r != DTM_IDLE);
   assign vref_busy_o = vref_busy_r;
   assign odt_on_o = odt_r;

endmodule
`default_nettype wire

// ---- tb/dtm_training_core_properties.sv ----
// port assertions for dtm_training_core
// assumes the bind below reaches every core instance
`timescale 1ns/10ps
`default_nettype none
`include "dtm_cfg.svh"

module dtm_training_core_chk
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic cke_i,
   input wire logic cs_i,
   input wire logic [`DTM_CA_W-1:0] ca_i,
   input wire logic vref_step_i,
   input wire logic vref_multi_i,
   input wire logic [`DTM_CA_W-1:0] dq_o,
   input wire logic [`DTM_CA_W-1:0] dq_oe_o,
   input wire logic sample_valid_o,
   input wire logic training_o,
   input wire logic vref_busy_o,
   input wire logic odt_on_o
);
   default clocking dck @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   sequence s_step;
      training_o && vref_step_i && !vref_busy_o;
   endsequence
   AST_ENTRY:
   assert property ($rose(training_o) |-> odt_on_o ##1 odt_on_o ##1 !odt_on_o)
      else $error("termination off too early or late");
   AST_SAMPLE:
   assert property (training_o && cs_i ##1 !cs_i |=> ##1 sample_valid_o && dq_o == $past(ca_i, 3) && dq_oe_o == 6'h3F)
      else $error("sample not returned");
   AST_VREF_LONG:
   assert property (s_step ##0 vref_multi_i |=> vref_busy_o [*2] ##1 !vref_busy_o)
      else $error("long step length wrong");
   AST_VREF_SHORT:
   assert property (s_step ##0 !vref_multi_i |=> vref_busy_o ##1 !vref_busy_o)
      else $error("short step length wrong");
   AST_EXIT:
   assert property ($rose(cke_i) && training_o |=> $stable(dq_oe_o) ##1 $stable(dq_oe_o) && !odt_on_o
      ##1 dq_oe_o == '0 && !training_o && odt_on_o)
      else $error("exit timing wrong");
endmodule

bind dtm_training_core dtm_training_core_chk i_chk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cke_i(cke_i),
   .cs_i(cs_i), .ca_i(ca_i), .vref_step_i(vref_step_i), .vref_multi_i(vref_multi_i), .dq_o(dq_o),
   .dq_oe_o(dq_oe_o), .sample_valid_o(sample_valid_o), .training_o(training_o), .vref_busy_o(vref_busy_o),
   .odt_on_o(odt_on_o));
`default_nettype wire

// ---- tb/dtm_ctrl_model.sv ----
// controller model driving the training inputs
// assumes a free clock; moves land 1 ns after a rising edge
`timescale 1ns/10ps
`default_nettype none
`include "dtm_cfg.svh"

module dtm_ctrl_model
(
   input wire logic clk_i,
   output logic cke_o,
   output logic cs_o,
   output logic [`DTM_CA_W-1:0] ca_o,
   output logic dqs_t_o,
   output logic dqs_c_o,
   output logic ten_o,
   output logic stp_o,
   output logic mul_o
);
   // row-to-column delay of the part in use, in cycles; plain default
   localparam int ROW_DELAY_CYC = 2;
   function automatic int cyc(input int ps, input int n);
      int c;
      c = (ps + `DTM_CLK_PERIOD_PS - 1) / `DTM_CLK_PERIOD_PS;
      return (c > n) ? c : n;
   endfunction
   initial
   begin
      cke_o = 1'b1;
      cs_o = 1'b0;
      ca_o = 6'h00;
      dqs_t_o = 1'b1;
      dqs_c_o = 1'b0;
      ten_o = 1'b1;
      stp_o = 1'b0;
      mul_o = 1'b0;
   end
   // clock never stops, so clock-valid windows hold
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic enter(input logic ok, input logic en);
      // the mode write arming training is taken as just issued
      tick(cyc(14000, 10));
      ten_o = en;
      dqs_t_o = !ok;
      dqs_c_o = ok;
      tick(cyc(10000, 1));
      cke_o = 1'b0;
      tick(cyc(250000, 5));
   endtask
   task automatic cmd(input logic [`DTM_CA_W-1:0] a, input logic [`DTM_CA_W-1:0] b, input logic two);
      cs_o = 1'b1;
      ca_o = a;
      tick(1);
      if (two)
      begin
         ca_o = b;
         tick(1);
      end
      cs_o = 1'b0;
      ca_o = ~ca_o;
      tick(cyc(20000, 1));
   endtask
   task automatic leave();
      tick(cyc(1750, 3));
      cke_o = 1'b1;
      tick(cyc(10000, 1));
      // released strobe shows the inverse, not a stale level
      dqs_t_o = !dqs_t_o;
      dqs_c_o = !dqs_c_o;
   endtask
   // readback of the trained setting waits exit time, row delay, three cycles
   task automatic settle();
      tick(cyc(7500, 5) + ROW_DELAY_CYC + 3);
   endtask
   task automatic step(input logic m);
      stp_o = 1'b1;
      mul_o = m;
      tick(1);
      stp_o = 1'b0;
      mul_o = !m;
   endtask
endmodule
`default_nettype wire

// ---- tb/tb_dtm_training_core.sv ----
// bench for dtm_training_core
// assumes the controller model drives every core input except clock and reset
`timescale 1ns/10ps
`default_nettype none
`include "dtm_cfg.svh"

module tb_dtm_training_core;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cke, cs, dt, dc, ten, stp, mul, vld, trn, bsy, odt;
   logic [`DTM_CA_W-1:0] ca, dq, oe;
   int error_cnt = 0;
   int n_compared = 0;
   int ticks = 0;
   always #50 clk = ~clk;
   dtm_ctrl_model i_ctrl (.clk_i(clk), .cke_o(cke), .cs_o(cs), .ca_o(ca), .dqs_t_o(dt), .dqs_c_o(dc),
      .ten_o(ten), .stp_o(stp), .mul_o(mul));
   dtm_training_core i_dut (.ref_clk_i(clk), .reset_n_i(rst_n), .train_en_i(ten), .cke_i(cke), .cs_i(cs),
      .ca_i(ca), .dqs_t_i(dt), .dqs_c_i(dc), .vref_step_i(stp), .vref_multi_i(mul), .dq_o(dq), .dq_oe_o(oe),
      .sample_valid_o(vld), .training_o(trn), .vref_busy_o(bsy), .odt_on_o(odt));
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk)
   begin
      ticks++;
      if (ticks == 500)
      begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic t_entry();
      i_ctrl.enter(1'b0, 1'b1);
      chk("training", 0, trn);
      i_ctrl.leave();
      i_ctrl.tick(1);
      // parked strobe but entry not allowed
      i_ctrl.enter(1'b1, 1'b0);
      chk("training", 0, trn);
      i_ctrl.leave();
      i_ctrl.tick(1);
      i_ctrl.enter(1'b1, 1'b1);
      chk("training", 1, trn);
      chk("odt", 0, odt);
   endtask
   task automatic t_sample();
      i_ctrl.cmd(6'h2A, 6'h00, 1'b0);
      i_ctrl.tick(1);
      chk("dq", 8'h2A, dq);
      chk("dq_oe", 8'h3F, oe);
      chk("valid", 1, vld);
      // second beat of a two-beat command lands before the first beat returns
      i_ctrl.cmd(6'h15, 6'h2C, 1'b1);
      chk("held dq", 8'h2A, dq);
      chk("valid dropped", 0, vld);
      i_ctrl.tick(1);
      chk("last dq", 8'h2C, dq);
   endtask
   task automatic t_vref();
      int n;
      for (int m = 0; m < 2; m++)
      begin
         n = 0;
         i_ctrl.step(m[0]);
         repeat (4)
         begin
            n += (bsy === 1'b1);
            i_ctrl.tick(1);
         end
         chk("busy cycles", m ? 8'd2 : 8'd1, n[7:0]);
      end
   endtask
   task automatic t_exit();
      i_ctrl.leave();
      i_ctrl.tick(1);
      chk("dq_oe", 8'h3F, oe);
      chk("odt", 0, odt);
      i_ctrl.tick(1);
      chk("dq_oe", 8'h00, oe);
      chk("training", 0, trn);
      i_ctrl.tick(1);
      chk("odt", 1, odt);
      i_ctrl.settle();
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      #1;
      chk("odt", 1, odt);
      chk("dq_oe", 0, oe);
      rst_n = 1'b1;
      i_ctrl.tick(3);
      t_entry();
      t_sample();
      t_vref();
      t_exit();
      tally_and_finish();
   end
endmodule
`default_nettype wire
